// >>> design/pll_clock_control_pkg.sv
// Constants shared by the PLL clock control block
`default_nettype none
package pll_clock_control_pkg;
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;
	localparam logic [1:0] PLL_CONTROL_OFS = 2'h0;
	localparam logic [1:0] BANDWIDTH_CONTROL_OFS = 2'h1;
	localparam logic [1:0] PLL_PROGRAM_OFS = 2'h2;
	// pll_control_reg fields
	localparam int IRQ_EN_BIT = 7;
	localparam int FLAG_BIT = 6;
	localparam int PWR_BIT = 5;
	localparam int BCS_BIT = 4;
	localparam logic [3:0] CTL_UNUSED_READ = 4'h f;
	// bandwidth_control_reg fields
	localparam int AUTO_BIT = 7;
	localparam int LOCK_BIT = 6;
	localparam int TRACK_BIT = 5;
	localparam int XLOSS_BIT = 4;
	// pll_program_reg fields
	localparam int MUL_LSB = 4;
	localparam int RANGE_LSB = 0;
	localparam logic [3:0] MUL_RESET = 4'h6;
	localparam logic [3:0] RANGE_RESET = 4'h6;
	localparam logic PWR_RESET = 1'b1;
	// Source edges to wait for on a switch-over
	localparam logic [1:0] SWITCH_EDGES = 2'h3;
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_SWITCH = 2'b10
	} switch_state_t;
endpackage
`default_nettype wire

// >>> design/pll_clock_control.sv
// PLL clock control: register file, base clock selector and lock flag
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`default_nettype none
// What this block does
// - Select bit picks VCO or crystal, halved
// - Output frozen while switching sources
// - Select needs the old power bit; the old select bit holds power
// - Control register low nibble reads ones
// - Auto bandwidth bit, reset to manual
// - Lock reads status in auto, else zero
// - Tracking bit: status auto, control manual
// - Manual tracking value held during auto
// - Write one, wait, read crystal loss
// - Crystal loss reads zero unless VCO selected
// - Multiplier zero acts as one, reset six
// - Multiplier locked while PLL powered
// - Range locked while PLL powered
// - Zero range disables PLL, blocks select
// - Lock change sets flag in auto
// - Manual mode: no irq, flag zero
// - Select allowed while unlocked
// - Stop holds clock and irq outputs low, disables PLL
// - Stop clears select bit
// - Break protects flag unless clear enabled
// - Control register access clears flag
// - Switch waits three edges of each source
// - Irq enable forced zero in manual
module pll_clock_control (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [pll_clock_control_pkg::ADDR_W-1:0] i_addr,
	input wire logic [pll_clock_control_pkg::DATA_W-1:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [pll_clock_control_pkg::DATA_W-1:0] o_rd_data,
	input wire logic i_crystal_clock,
	input wire logic i_vco_clock,
	input wire logic i_pll_locked,
	input wire logic i_pll_tracking,
	input wire logic i_osc_enable_in,
	input wire logic i_break_active,
	input wire logic i_break_clear_enable,
	output logic o_base_clock_out,
	output logic o_crystal_clock,
	output logic o_lock_irq_out,
	output logic o_pll_enable,
	output logic o_auto_bandwidth,
	output logic o_manual_tracking,
	output logic [3:0] o_feedback_multiplier,
	output logic [3:0] o_vco_range_factor
);
	// Source clocks are sampled, so each must stay below half of i_ref_clk
	function automatic logic [3:0] eff_mul(input logic [3:0] m);
		eff_mul = (m == 4'h0) ? 4'h1 : m;
	endfunction

	// Saturating edge counter for the switch-over
	function automatic logic [1:0] count_edge(input logic [1:0] c, input logic e);
		count_edge = (e && c != pll_clock_control_pkg::SWITCH_EDGES) ? c + 2'h1 : c;
	endfunction

	function automatic logic addr_hit(input logic [1:0] a, input logic [1:0] ofs);
		addr_hit = a == ofs;
	endfunction

	// Software-visible register bits
	logic lock_irq_enable;
	logic lock_change_flag;
	logic pll_power_on;
	logic base_clock_select;
	logic auto_bw;
	logic manual_track;
	logic crystal_loss_flag;
	logic [3:0] feedback_multiplier;
	logic [3:0] vco_range_factor;

	// Edge history and clock selector
	logic lock_prev;
	logic xclk_prev;
	logic vclk_prev;
	logic active_vco;
	pll_clock_control_pkg::switch_state_t st;
	logic [1:0] xcnt;
	logic [1:0] vcnt;
	logic div_q;

	// Output flops
	logic [7:0] rd_data;
	logic crystal_q;
	logic irq_q;
	logic pll_en_q;

	// Next values, grouped as above
	logic next_lock_irq_enable;
	logic next_lock_change_flag;
	logic next_pll_power_on;
	logic next_base_clock_select;
	logic next_auto_bw;
	logic next_manual_track;
	logic next_crystal_loss_flag;
	logic [3:0] next_feedback_multiplier;
	logic [3:0] next_vco_range_factor;

	logic next_active_vco;
	pll_clock_control_pkg::switch_state_t next_st;
	logic [1:0] next_xcnt;
	logic [1:0] next_vcnt;
	logic next_div_q;

	logic [7:0] next_rd_data;
	logic next_crystal_q;
	logic next_irq_q;
	logic next_pll_en_q;

	// Decodes and events
	logic wr_ctl;
	logic wr_bw;
	logic wr_prog;
	logic x_edge;
	logic v_edge;
	logic lock_seen;
	logic flag_clear;
	logic range_zero;

	// Register file next state
	always_comb begin
		wr_ctl = i_wr && addr_hit(i_addr, pll_clock_control_pkg::PLL_CONTROL_OFS);
		wr_bw = i_wr && addr_hit(i_addr, pll_clock_control_pkg::BANDWIDTH_CONTROL_OFS);
		wr_prog = i_wr && addr_hit(i_addr, pll_clock_control_pkg::PLL_PROGRAM_OFS);
		// Source edges, seen one reference cycle late
		x_edge = i_crystal_clock && !xclk_prev;
		v_edge = i_vco_clock && !vclk_prev;
		lock_seen = auto_bw && i_pll_locked;
		range_zero = vco_range_factor == 4'h0;
		// Read or write of the control register, guarded in break
		flag_clear = (i_rd || i_wr) && addr_hit(i_addr, pll_clock_control_pkg::PLL_CONTROL_OFS)
			&& (!i_break_active || i_break_clear_enable);

		// Hold unless written or forced
		next_lock_irq_enable = lock_irq_enable;
		next_pll_power_on = pll_power_on;
		next_base_clock_select = base_clock_select;
		next_auto_bw = auto_bw;
		next_manual_track = manual_track;
		next_crystal_loss_flag = crystal_loss_flag;
		next_feedback_multiplier = feedback_multiplier;
		next_vco_range_factor = vco_range_factor;

		if (wr_ctl) begin
			next_lock_irq_enable = i_wr_data[pll_clock_control_pkg::IRQ_EN_BIT];
			// Power cannot drop while VCO drives the output
			next_pll_power_on = i_wr_data[pll_clock_control_pkg::PWR_BIT]
				|| base_clock_select;
			// Uses the old power bit, so power-up and select take two writes
			next_base_clock_select = i_wr_data[pll_clock_control_pkg::BCS_BIT]
				&& pll_power_on && !range_zero;
		end

		if (wr_bw) begin
			next_auto_bw = i_wr_data[pll_clock_control_pkg::AUTO_BIT];
			if (!auto_bw) begin
				next_manual_track = i_wr_data[pll_clock_control_pkg::TRACK_BIT];
			end
			// A probe starts by writing one; any crystal edge clears it
			if (i_wr_data[pll_clock_control_pkg::XLOSS_BIT]) begin
				next_crystal_loss_flag = 1'b1;
			end
		end

		if (wr_prog && !pll_power_on) begin
			next_feedback_multiplier = i_wr_data[pll_clock_control_pkg::MUL_LSB +: 4];
			next_vco_range_factor = i_wr_data[pll_clock_control_pkg::RANGE_LSB +: 4];
		end

		// Forced values last, so they beat any write
		// Loss probe means nothing with the crystal source
		if (x_edge || !base_clock_select) begin
			next_crystal_loss_flag = 1'b0;
		end
		if (!next_auto_bw) begin
			next_lock_irq_enable = 1'b0;
		end
		if (next_vco_range_factor == 4'h0 || !i_osc_enable_in) begin
			next_base_clock_select = 1'b0;
		end

		// Set wins over a clear in the same cycle
		next_lock_change_flag = lock_change_flag && !flag_clear;
		if (auto_bw && lock_seen != lock_prev) begin
			next_lock_change_flag = 1'b1;
		end
		if (!auto_bw) begin
			next_lock_change_flag = 1'b0;
		end
	end

	// Base clock selector: run, or frozen while switching
	always_comb begin
		next_st = st;
		next_active_vco = active_vco;
		next_xcnt = count_edge(xcnt, x_edge);
		next_vcnt = count_edge(vcnt, v_edge);
		next_div_q = div_q;
		case (st)
			pll_clock_control_pkg::ST_RUN: begin
				next_xcnt = 2'h0;
				next_vcnt = 2'h0;
				if (base_clock_select != active_vco) begin
					next_st = pll_clock_control_pkg::ST_SWITCH;
				// One toggle per source edge halves the source
				end else if (active_vco ? v_edge : x_edge) begin
					next_div_q = !div_q;
				end
			end
			pll_clock_control_pkg::ST_SWITCH: begin
				// Output holds its level here
				if (next_xcnt == pll_clock_control_pkg::SWITCH_EDGES
					&& next_vcnt == pll_clock_control_pkg::SWITCH_EDGES) begin
					next_active_vco = base_clock_select;
					next_st = pll_clock_control_pkg::ST_RUN;
				end
			end
			default: begin
				next_st = pll_clock_control_pkg::ST_RUN;
			end
		endcase

		// Stop: VCO may be dead, so abandon any switch-over
		if (!i_osc_enable_in) begin
			next_st = pll_clock_control_pkg::ST_RUN;
			next_active_vco = 1'b0;
			next_div_q = 1'b0;
		end
	end

	// Read port and output flops
	always_comb begin
		next_rd_data = 8'h00;
		if (i_rd) begin
			case (i_addr)
				pll_clock_control_pkg::PLL_CONTROL_OFS: begin
					next_rd_data = {lock_irq_enable, lock_change_flag && auto_bw,
						pll_power_on, base_clock_select,
						pll_clock_control_pkg::CTL_UNUSED_READ};
				end
				pll_clock_control_pkg::BANDWIDTH_CONTROL_OFS: begin
					next_rd_data = {auto_bw, lock_seen,
						auto_bw ? i_pll_tracking : manual_track,
						crystal_loss_flag && base_clock_select, 4'h0};
				end
				pll_clock_control_pkg::PLL_PROGRAM_OFS: begin
					next_rd_data = {feedback_multiplier, vco_range_factor};
				end
				default: begin
					next_rd_data = 8'h00;
				end
			endcase
		end

		// Stop holds every clock and irq output low
		next_crystal_q = i_osc_enable_in && i_crystal_clock;
		next_irq_q = i_osc_enable_in && auto_bw
			&& lock_change_flag && lock_irq_enable;
		next_pll_en_q = i_osc_enable_in && pll_power_on && !range_zero;
	end

	// Register file flops
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			lock_irq_enable <= 1'b0;
			lock_change_flag <= 1'b0;
			pll_power_on <= pll_clock_control_pkg::PWR_RESET;
			base_clock_select <= 1'b0;
			auto_bw <= 1'b0;
			manual_track <= 1'b0;
			crystal_loss_flag <= 1'b0;
			feedback_multiplier <= pll_clock_control_pkg::MUL_RESET;
			vco_range_factor <= pll_clock_control_pkg::RANGE_RESET;
			lock_prev <= 1'b0;
		end else begin
			lock_irq_enable <= next_lock_irq_enable;
			lock_change_flag <= next_lock_change_flag;
			pll_power_on <= next_pll_power_on;
			base_clock_select <= next_base_clock_select;
			auto_bw <= next_auto_bw;
			manual_track <= next_manual_track;
			crystal_loss_flag <= next_crystal_loss_flag;
			feedback_multiplier <= next_feedback_multiplier;
			vco_range_factor <= next_vco_range_factor;
			lock_prev <= lock_seen;
		end
	end

	// Selector flops
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			xclk_prev <= 1'b0;
			vclk_prev <= 1'b0;
			active_vco <= 1'b0;
			st <= pll_clock_control_pkg::ST_RUN;
			xcnt <= 2'h0;
			vcnt <= 2'h0;
			div_q <= 1'b0;
		end else begin
			xclk_prev <= i_crystal_clock;
			vclk_prev <= i_vco_clock;
			active_vco <= next_active_vco;
			st <= next_st;
			xcnt <= next_xcnt;
			vcnt <= next_vcnt;
			div_q <= next_div_q;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rd_data <= 8'h00;
			crystal_q <= 1'b0;
			irq_q <= 1'b0;
			pll_en_q <= 1'b0;
		end else begin
			rd_data <= next_rd_data;
			crystal_q <= next_crystal_q;
			irq_q <= next_irq_q;
			pll_en_q <= next_pll_en_q;
		end
	end

	// Ports come straight from flops, the multiplier through eff_mul
	always_comb begin
		o_rd_data = rd_data;
		o_base_clock_out = div_q;
		o_crystal_clock = crystal_q;
		o_lock_irq_out = irq_q;
		o_pll_enable = pll_en_q;
		o_auto_bandwidth = auto_bw;
		o_manual_tracking = manual_track;
		o_feedback_multiplier = eff_mul(feedback_multiplier);
		o_vco_range_factor = vco_range_factor;
	end
endmodule
`default_nettype wire

// >>> testbench/pll_far_side_model.sv
// Far-side model: crystal, VCO and analog lock status
`default_nettype none
module pll_far_side_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_pll_on,
	input wire logic i_xtal_run,
	input wire logic i_noise,
	output logic o_xtal,
	output logic o_vco,
	output logic o_locked,
	output logic o_tracking
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] div;
	logic [3:0] age;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			div <= 4'h0;
			age <= 4'h0;
		end else begin
			div <= div + 4'h1;
			age <= !i_pll_on ? 4'h0 : age + {3'h0, age != 4'hf};
		end
	end
	// A dead crystal stays low
	assign o_xtal = i_xtal_run & div[2];
	assign o_vco = i_pll_on & div[1];
	// Noise hit knocks the loop out of lock
	assign o_locked = (age == 4'hf) & !i_noise;
	assign o_tracking = age[3];
endmodule
`default_nettype wire

// >>> testbench/pll_clock_control_monitor.sv
// Port checks for the PLL clock control block
`default_nettype none
module pll_clock_control_monitor (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [1:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rd_data,
	input wire logic i_osc_enable_in,
	input wire logic o_base_clock_out,
	input wire logic o_crystal_clock,
	input wire logic o_lock_irq_out,
	input wire logic o_pll_enable,
	input wire logic o_auto_bandwidth,
	input wire logic [3:0] o_feedback_multiplier,
	input wire logic [3:0] o_vco_range_factor
);
	logic ctl_rd;
	logic man;
	assign ctl_rd = i_rd && i_addr == 2'h0;
	assign man = !o_auto_bandwidth;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	sequence stopped;
		!i_osc_enable_in ##1 !i_osc_enable_in;
	endsequence
	chk_unused_ones: assert property (ctl_rd |=> o_rd_data[3:0] == 4'hf)
		else $error("control low bits not ones");
	chk_manual_irq_bits: assert property (ctl_rd && man |=> o_rd_data[7:6] == 2'h0)
		else $error("irq bits set in manual");
	chk_manual_lock: assert property (i_rd && i_addr == 2'h1 && man |=> !o_rd_data[6])
		else $error("lock set in manual");
	chk_manual_no_irq: assert property (man |=> !o_lock_irq_out)
		else $error("irq in manual");
	chk_irq_cause: assert property (o_lock_irq_out |-> $past(o_auto_bandwidth))
		else $error("irq without auto");
	chk_stop_quiet: assert property (stopped |-> !o_crystal_clock && !o_base_clock_out
		&& !o_lock_irq_out && !o_pll_enable)
		else $error("outputs active in stop");
	chk_stop_select: assert property (stopped ##0 ctl_rd |=> !o_rd_data[4])
		else $error("select kept in stop");
	chk_prog_frozen: assert property (o_pll_enable && !$past(i_wr && i_addr == 2'h0)
		&& i_wr && i_addr == 2'h2 |=> $stable(o_feedback_multiplier)
		&& $stable(o_vco_range_factor))
		else $error("programming written while on");
	chk_mul_nonzero: assert property (o_feedback_multiplier != 4'h0)
		else $error("multiplier zero");
	chk_range_zero_off: assert property (o_vco_range_factor == 4'h0 |=> !o_pll_enable)
		else $error("pll on with zero range");
endmodule
bind pll_clock_control pll_clock_control_monitor i_mon (.i_ref_clk, .i_sys_rst, .i_addr, .i_wr,
	.i_rd, .o_rd_data, .i_osc_enable_in, .o_base_clock_out, .o_crystal_clock, .o_lock_irq_out,
	.o_pll_enable, .o_auto_bandwidth, .o_feedback_multiplier, .o_vco_range_factor);
`default_nettype wire

// >>> testbench/pll_clock_control_tb.sv
// Self-checking bench for the PLL clock control block
`default_nettype none
module pll_clock_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, wr, rd, osc, brk, brk_clr, xrun, noise, pb;
	logic xtal, vco, lck, trk, base, xout, irq, pen, auto, mtrk;
	logic [1:0] addr;
	logic [7:0] wdat, rdat, v;
	logic [3:0] mul, rng;
	int failures, tests_run, n;
	pll_clock_control i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wdat),
		.i_wr(wr), .i_rd(rd), .o_rd_data(rdat), .i_crystal_clock(xtal), .i_vco_clock(vco),
		.i_pll_locked(lck), .i_pll_tracking(trk), .i_osc_enable_in(osc), .i_break_active(brk),
		.i_break_clear_enable(brk_clr), .o_base_clock_out(base), .o_crystal_clock(xout),
		.o_lock_irq_out(irq), .o_pll_enable(pen), .o_auto_bandwidth(auto),
		.o_manual_tracking(mtrk), .o_feedback_multiplier(mul), .o_vco_range_factor(rng));
	pll_far_side_model i_far (.i_clk(clk), .i_rst(rst), .i_pll_on(pen), .i_xtal_run(xrun),
		.i_noise(noise), .o_xtal(xtal), .o_vco(vco), .o_locked(lck), .o_tracking(trk));
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [7:0] ctl(input logic en, fl, pw, se);
		return {en, fl, pw, se, 4'hf};
	endfunction
	function automatic logic [3:0] eff_mul(input logic [3:0] m);
		return (m == 4'h0) ? 4'h1 : m;
	endfunction
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wreg(input logic [1:0] a, input logic [7:0] x);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdat <= x;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rreg(input logic [1:0] a, input logic [7:0] e, input string nm);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1 chk(nm, e, rdat);
	endtask
	// Counts base output changes over a window
	task automatic toggles(input int cyc);
		n = 0;
		#1 pb = base;
		repeat (cyc) begin
			@(posedge clk);
			#1 n += int'(base !== pb);
			pb = base;
		end
	endtask
	initial begin
		void'($urandom(91213));
		{failures, tests_run} = '0;
		{rst, osc, xrun} = 3'h7;
		{wr, rd, brk, brk_clr, noise, addr, wdat} = '0;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rreg(2'h0, ctl(0, 0, 1, 0), "ctl reset");
		rreg(2'h1, 8'h00, "bw reset");
		rreg(2'h2, 8'h66, "prog reset");
		rreg(2'h3, 8'h00, "unmapped");
		wreg(2'h2, 8'h11);
		rreg(2'h2, 8'h66, "prog locked");
		wreg(2'h0, 8'h30);
		toggles(12);
		chk("frozen", 8'h00, 8'(n));
		rreg(2'h0, ctl(0, 0, 1, 1), "select unlocked");
		repeat (20) @(posedge clk);
		toggles(80);
		chk("vco rate", 8'h01, 8'(n >= 19 && n <= 21));
		@(posedge clk) xrun <= 1'h0;
		wreg(2'h1, 8'h10);
		repeat (96) @(posedge clk);
		rreg(2'h1, 8'h10, "crystal lost");
		@(posedge clk) xrun <= 1'h1;
		wreg(2'h1, 8'h10);
		repeat (96) @(posedge clk);
		rreg(2'h1, 8'h00, "crystal ok");
		wreg(2'h0, 8'h10);
		rreg(2'h0, ctl(0, 0, 1, 1), "power kept");
		wreg(2'h0, 8'h20);
		wreg(2'h1, 8'h10);
		rreg(2'h1, 8'h00, "loss needs select");
		repeat (30) @(posedge clk);
		toggles(80);
		chk("xtal rate", 8'h01, 8'(n >= 9 && n <= 11));
		wreg(2'h0, 8'h00);
		wreg(2'h0, 8'h10);
		rreg(2'h0, ctl(0, 0, 0, 0), "select refused");
		for (int i = 0; i < 5; i++) begin
			v = (i == 0) ? 8'h00 : 8'($urandom);
			wreg(2'h2, v);
			rreg(2'h2, v, "prog");
			chk("mul", {4'h0, eff_mul(v[7:4])}, {4'h0, mul});
			chk("range", {4'h0, v[3:0]}, {4'h0, rng});
		end
		wreg(2'h2, 8'h60);
		wreg(2'h0, 8'h20);
		wreg(2'h0, 8'h30);
		rreg(2'h0, ctl(0, 0, 1, 0), "zero range");
		chk("pll off", 8'h00, {7'h0, pen});
		wreg(2'h0, 8'h00);
		wreg(2'h2, 8'h66);
		wreg(2'h1, 8'h20);
		rreg(2'h1, 8'h20, "manual track");
		wreg(2'h1, 8'ha0);
		#1 chk("held track", 8'h01, {7'h0, mtrk});
		rreg(2'h1, 8'h80, "auto status");
		wreg(2'h0, 8'ha0);
		n = 0;
		while (irq !== 1'h1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk("irq", 8'h01, {7'h0, irq});
		if (n == 100) final_report();
		rreg(2'h1, 8'he0, "locked");
		@(posedge clk) brk <= 1'h1;
		rreg(2'h0, ctl(1, 1, 1, 0), "break 1");
		rreg(2'h0, ctl(1, 1, 1, 0), "break 2");
		@(posedge clk) brk <= 1'h0;
		rreg(2'h0, ctl(1, 1, 1, 0), "flag read");
		rreg(2'h0, ctl(1, 0, 1, 0), "flag cleared");
		chk("irq off", 8'h00, {7'h0, irq});
		@(posedge clk) noise <= 1'h1;
		repeat (4) @(posedge clk);
		{brk, brk_clr} <= 2'h3;
		rreg(2'h0, ctl(1, 1, 1, 0), "break clr");
		@(posedge clk) {brk, brk_clr} <= 2'h0;
		rreg(2'h0, ctl(1, 0, 1, 0), "clr persists");
		wreg(2'h1, 8'h00);
		rreg(2'h0, ctl(0, 0, 1, 0), "manual irq");
		wreg(2'h0, 8'h30);
		@(posedge clk) osc <= 1'h0;
		repeat (3) @(posedge clk);
		#1 chk("stop outs", 8'h00, {5'h0, base, xout, irq});
		rreg(2'h0, ctl(0, 0, 1, 0), "stop select");
		@(posedge clk) osc <= 1'h1;
		final_report();
	end
endmodule
`default_nettype wire
